// File: common/gsfs_defs.vh
// Constants of the gating sequence fault supervisor
`ifndef GSFS_DEFS_VH
`define GSFS_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GSFS_OFS_STATUS 5'h00
`define GSFS_OFS_MASK 5'h04
`define GSFS_OFS_CONTROL 5'h08
`define GSFS_OFS_ERROR 5'h0C
`define GSFS_OFS_STATE 5'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define GSFS_ST_FAULT 0
`define GSFS_ST_LOCK 1
`define GSFS_ST_START 2
`define GSFS_EV_W 3
`define GSFS_MASK_RST 3'h0
`define GSFS_CTRL_RST 1'b1
`define GSFS_CTRL_GATE_EN 0

// ----------------------------------------
// Error codes, the decimal number in binary
// ----------------------------------------
`define GSFS_E_NONE 8'h00
`define GSFS_E41 8'h29
`define GSFS_E60 8'h3C
`define GSFS_E61 8'h3D
`define GSFS_E62 8'h3E
`define GSFS_E63 8'h3F
`define GSFS_E64 8'h40
`define GSFS_E65 8'h41
`define GSFS_E66 8'h42
`define GSFS_E67 8'h43
`define GSFS_E68 8'h44
`define GSFS_E70 8'h46
`define GSFS_E71 8'h47
`define GSFS_E74 8'h4A
`define GSFS_E75 8'h4B
`define GSFS_E76 8'h4C
`define GSFS_E79 8'h4F

// ----------------------------------------
// Timing, times in milliseconds
// ----------------------------------------
`define GSFS_CLK_HZ 25000000
`define GSFS_T_TICK_MS 100
`define GSFS_T_FIELD_MS 3700
`define GSFS_T_WIN2_MS 2000
`define GSFS_T_WIN4_MS 4000
`define GSFS_T_PROC_MS 3600000
`define GSFS_T_OVR_OFF_MS 120000
`define GSFS_T_OVR_LOCK_MS 150000
`define GSFS_T_SYNC_MS 60000
`define GSFS_T_END_MS 20000
`define GSFS_T_CSMIN_MS 4000
`define GSFS_T_GATE_MS 60000
`define GSFS_TK(ms) ((ms) / `GSFS_T_TICK_MS)
`define GSFS_TICK_CYC (`GSFS_CLK_HZ / 1000 * `GSFS_T_TICK_MS)

`endif

// File: core/gsfs_tick_timer.v
// Saturating counter of time-base ticks with synchronous clear
`timescale 1ns/1ns
module gsfs_tick_timer #(
  parameter W = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire tick,
  input wire clear,
  output reg [W-1:0] count
);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (clkEn) begin
      if (clear) begin
        count <= {W{1'b0}};
      end else if (tick && (count != {W{1'b1}})) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// File: core/gsfs_supervisor.v
// Gating sequence fault supervisor with Avalon-MM register slave
//
// Overview of operation
// - Polarity mode change: lock, report E41
// - Beam configuration fault: outputs off, E60
// - Response time exceeded: off, E61, reboot
// - Overlapping blanking areas: off, E62
// - Modes 1,4: field interrupted >3.7 s, E63
// - Field interrupted after window: off, E64
// - Process mode 1 h, control high: E65
// - Override: control drops before clear, E66
// - Override modes 1,6: extension drops, E67
// - Override: off 120 s, lock 150 s, E68
// - Field interrupted without control, sync 1 min: E70
// - Violation before sequence reset: off, E71
// - Control rises while interlocked: stay off, E74
// - Control held 20 s after end: E75
// - Mode 5: control removed before 4 s, E76
// - Gating timeout: off, E79; extension avoids
`timescale 1ns/1ns
`include "gsfs_defs.vh"
module gsfs_supervisor #(
  parameter TICK_CYCLES = `GSFS_TICK_CYC,
  parameter TW = 16,
  parameter GATE_MS = `GSFS_T_GATE_MS
) (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire gatingControl,
  input wire gatingExtensionSignal,
  input wire fieldInterrupted,
  input wire syncInterrupted,
  input wire restartButton,
  input wire [2:0] operatingModeNumber,
  input wire polarityModeChange,
  input wire beamConfigFault,
  input wire responseTimeExceeded,
  input wire blankingOverlap,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg safetySwitchingOutput,
  output reg lockedState,
  output reg [7:0] errorCode,
  output reg irq
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_WAIT = 8'h02;
  localparam [7:0] S_PROC = 8'h04;
  localparam [7:0] S_GATE = 8'h08;
  localparam [7:0] S_OVR = 8'h10;
  localparam [7:0] S_END = 8'h20;
  localparam [7:0] S_FAULT = 8'h40;
  localparam [7:0] S_LOCK = 8'h80;

  // Limits stay integers so comparisons widen the timer instead of cutting the limit
  localparam integer K_FIELD = `GSFS_TK(`GSFS_T_FIELD_MS);
  localparam integer K_WIN2 = `GSFS_TK(`GSFS_T_WIN2_MS);
  localparam integer K_WIN4 = `GSFS_TK(`GSFS_T_WIN4_MS);
  localparam integer K_PROC = `GSFS_TK(`GSFS_T_PROC_MS);
  localparam integer K_OVR_OFF = `GSFS_TK(`GSFS_T_OVR_OFF_MS);
  localparam integer K_OVR_LOCK = `GSFS_TK(`GSFS_T_OVR_LOCK_MS);
  localparam integer K_SYNC = `GSFS_TK(`GSFS_T_SYNC_MS);
  localparam integer K_END = `GSFS_TK(`GSFS_T_END_MS);
  localparam integer K_CSMIN = `GSFS_TK(`GSFS_T_CSMIN_MS);
  localparam integer K_GATE = `GSFS_TK(GATE_MS);
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [23:0] TICK_LAST = TICK_LAST_I[23:0];

  function hit;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  reg [7:0] state;
  reg [7:0] next_state;
  reg [7:0] setCode;
  reg lockReq;
  reg seqClear;
  reg csPrev;
  reg thPrev;
  reg resPrev;
  reg [23:0] preCount;
  reg tick;
  reg [`GSFS_EV_W-1:0] status;
  reg [`GSFS_EV_W-1:0] mask;
  reg gateEnable;
  reg [31:0] next_readdata;

  wire [4*TW-1:0] tAll;
  wire [3:0] tClr;
  wire [TW-1:0] seqTime = tAll[0 +: TW];
  wire [TW-1:0] fieldTime = tAll[TW +: TW];
  wire [TW-1:0] syncTime = tAll[2*TW +: TW];
  wire [TW-1:0] csTime = tAll[3*TW +: TW];

  wire csRise = gatingControl & ~csPrev;
  wire csFall = ~gatingControl & csPrev;
  wire thFall = ~gatingExtensionSignal & thPrev;
  wire resRise = restartButton & ~resPrev;
  wire m14 = (operatingModeNumber == 3'h1) || (operatingModeNumber == 3'h4);
  wire m16 = (operatingModeNumber == 3'h1) || (operatingModeNumber == 3'h6);
  wire m5 = (operatingModeNumber == 3'h5);
  wire [TW-1:0] window = (operatingModeNumber == 3'h4) ? K_WIN2[TW-1:0] : K_WIN4[TW-1:0];

  // ----------------------------------------
  // Time base and interval timers
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preCount <= 24'h000000;
      tick <= 1'b0;
    end else if (clkEn) begin
      tick <= (preCount == TICK_LAST);
      if (preCount == TICK_LAST) begin
        preCount <= 24'h000000;
      end else begin
        preCount <= preCount + 24'h000001;
      end
    end
  end

  // The extension signal keeps the gating timer from running out
  assign tClr[0] = seqClear | (state[3] & gatingExtensionSignal);
  assign tClr[1] = ~fieldInterrupted;
  assign tClr[2] = ~syncInterrupted;
  assign tClr[3] = ~gatingControl;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gTimer
      gsfs_tick_timer #(
        .W(TW)
      ) uTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .tick(tick),
        .clear(tClr[gi]),
        .count(tAll[gi*TW +: TW])
      );
    end
  endgenerate

  // ----------------------------------------
  // Sequence supervision
  // ----------------------------------------
  always @* begin
    next_state = state;
    setCode = `GSFS_E_NONE;
    lockReq = 1'b0;
    seqClear = 1'b0;
    if (!state[7]) begin
      if (polarityModeChange) begin
        setCode = `GSFS_E41;
        lockReq = 1'b1;
      end else if (responseTimeExceeded) begin
        // Only a reboot recovers, so treat it as locking
        setCode = `GSFS_E61;
        lockReq = 1'b1;
      end else if (beamConfigFault) begin
        setCode = `GSFS_E60;
      end else if (blankingOverlap) begin
        setCode = `GSFS_E62;
      end else if (syncTime >= K_SYNC) begin
        setCode = `GSFS_E70;
      end else if (m5 && csFall && (csTime < K_CSMIN) && (state[1] || state[3])) begin
        setCode = `GSFS_E76;
      end
    end
    if (setCode == `GSFS_E_NONE) begin
      case (state)
        S_IDLE: begin
          if (csRise && gateEnable) begin
            if (m14 && (fieldTime > K_FIELD)) begin
              setCode = `GSFS_E63;
            end else begin
              next_state = S_WAIT;
              seqClear = 1'b1;
            end
          end else if (fieldInterrupted && !m14) begin
            // Plain protective trip: restart interlock, no code
            next_state = S_FAULT;
          end
        end
        S_WAIT: begin
          if (fieldInterrupted) begin
            next_state = S_GATE;
            seqClear = 1'b1;
          end else if (csFall) begin
            next_state = S_IDLE;
          end else if (seqTime >= window) begin
            next_state = S_PROC;
          end
        end
        S_PROC: begin
          if (fieldInterrupted) begin
            setCode = `GSFS_E64;
          end else if (csFall) begin
            next_state = S_IDLE;
          end else if (seqTime >= K_PROC) begin
            setCode = `GSFS_E65;
          end
        end
        S_GATE: begin
          if (!fieldInterrupted) begin
            next_state = S_END;
            seqClear = 1'b1;
          end else if (csFall) begin
            setCode = `GSFS_E70;
          end else if (resRise) begin
            next_state = S_OVR;
            seqClear = 1'b1;
          end else if (seqTime >= K_GATE) begin
            setCode = `GSFS_E79;
          end
        end
        S_OVR: begin
          if (!fieldInterrupted) begin
            next_state = S_END;
            seqClear = 1'b1;
          end else if (csFall) begin
            setCode = `GSFS_E66;
          end else if (m16 && thFall) begin
            setCode = `GSFS_E67;
          end else if (seqTime >= K_OVR_OFF) begin
            // Timer keeps running in the fault state towards the lock
            setCode = `GSFS_E68;
          end
        end
        S_END: begin
          if (fieldInterrupted) begin
            setCode = `GSFS_E71;
          end else if (csFall) begin
            next_state = S_IDLE;
          end else if (seqTime >= K_END) begin
            setCode = `GSFS_E75;
          end
        end
        S_FAULT: begin
          if ((errorCode == `GSFS_E68) && (seqTime >= K_OVR_LOCK)) begin
            setCode = `GSFS_E68;
            lockReq = 1'b1;
          end else if (resRise) begin
            next_state = S_IDLE;
            seqClear = 1'b1;
          end else if (csRise && (errorCode == `GSFS_E_NONE)) begin
            setCode = `GSFS_E74;
          end
        end
        default: begin
          next_state = S_LOCK;
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      errorCode <= `GSFS_E_NONE;
      safetySwitchingOutput <= 1'b0;
      lockedState <= 1'b0;
      csPrev <= 1'b0;
      thPrev <= 1'b0;
      resPrev <= 1'b0;
    end else if (clkEn) begin
      csPrev <= gatingControl;
      thPrev <= gatingExtensionSignal;
      resPrev <= restartButton;
      if (setCode != `GSFS_E_NONE) begin
        errorCode <= setCode;
        state <= lockReq ? S_LOCK : S_FAULT;
        safetySwitchingOutput <= 1'b0;
        lockedState <= lockReq;
      end else begin
        state <= next_state;
        if (next_state == S_IDLE) begin
          errorCode <= `GSFS_E_NONE;
        end
        safetySwitchingOutput <= !(next_state[6] || next_state[7]);
        lockedState <= next_state[7];
      end
    end
  end

  // ----------------------------------------
  // Register slave and interrupt
  // ----------------------------------------
  // One wait state on every access; write and read data act when it drops
  wire busAcc = (avs_read | avs_write) & avs_waitrequest;
  wire busWr = avs_write & ~avs_waitrequest;
  wire [`GSFS_EV_W-1:0] events;
  wire [`GSFS_EV_W-1:0] w1c;

  assign events[`GSFS_ST_FAULT] = (setCode != `GSFS_E_NONE) & ~lockReq;
  assign events[`GSFS_ST_LOCK] = lockReq;
  assign events[`GSFS_ST_START] = state[0] & next_state[1] & (setCode == `GSFS_E_NONE);
  assign w1c = (busWr && hit(avs_address, `GSFS_OFS_STATUS)) ?
    avs_writedata[`GSFS_EV_W-1:0] : {`GSFS_EV_W{1'b0}};

  always @* begin
    next_readdata = 32'h00000000;
    if (hit(avs_address, `GSFS_OFS_STATUS)) begin
      next_readdata[`GSFS_EV_W-1:0] = status;
    end else if (hit(avs_address, `GSFS_OFS_MASK)) begin
      next_readdata[`GSFS_EV_W-1:0] = mask;
    end else if (hit(avs_address, `GSFS_OFS_CONTROL)) begin
      next_readdata[`GSFS_CTRL_GATE_EN] = gateEnable;
    end else if (hit(avs_address, `GSFS_OFS_ERROR)) begin
      next_readdata[7:0] = errorCode;
    end else if (hit(avs_address, `GSFS_OFS_STATE)) begin
      next_readdata[7:0] = state;
      next_readdata[8] = safetySwitchingOutput;
      next_readdata[9] = lockedState;
      next_readdata[12:10] = operatingModeNumber;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      status <= {`GSFS_EV_W{1'b0}};
      mask <= `GSFS_MASK_RST;
      gateEnable <= `GSFS_CTRL_RST;
      irq <= 1'b0;
    end else if (clkEn) begin
      avs_waitrequest <= ~busAcc;
      if (busAcc && avs_read) begin
        avs_readdata <= next_readdata;
      end
      // A new event wins over a clear in the same cycle
      status <= (status & ~w1c) | events;
      irq <= |(((status & ~w1c) | events) & mask);
      if (busWr && hit(avs_address, `GSFS_OFS_MASK)) begin
        mask <= avs_writedata[`GSFS_EV_W-1:0];
      end
      if (busWr && hit(avs_address, `GSFS_OFS_CONTROL)) begin
        gateEnable <= avs_writedata[`GSFS_CTRL_GATE_EN];
      end
    end
  end

endmodule

// File: test/gsfs_controller_model.sv
// Machine controller model driving the gating and restart signals
`timescale 1ns/1ns
module gsfs_controller_model (
  input wire ref_clk,
  input wire rst,
  input wire reqCtrl,
  input wire reqExt,
  input wire reqRestart,
  output logic gatingControl,
  output logic gatingExtensionSignal,
  output logic restartButton
);
  // ------
  // Registered outputs, one cycle behind the requests
  // ------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gatingControl <= 1'b0;
      gatingExtensionSignal <= 1'b0;
      restartButton <= 1'b0;
    end else begin
      gatingControl <= reqCtrl;
      gatingExtensionSignal <= reqExt;
      // Operator press starts a new sequence after a fault
      restartButton <= reqRestart;
    end
  end
endmodule

// File: test/gsfs_supervisor_checker.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/1ns
`include "gsfs_defs.vh"
module gsfs_supervisor_checker (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire gatingControl,
  input wire restartButton,
  input wire polarityModeChange,
  input wire beamConfigFault,
  input wire responseTimeExceeded,
  input wire blankingOverlap,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire safetySwitchingOutput,
  input wire lockedState,
  input wire [7:0] errorCode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_lock;
    polarityModeChange && !lockedState |=> lockedState && errorCode == `GSFS_E41;
  endproperty
  a_lock: assert property (p_lock) else $error("polarity lock missing");
  property p_beam;
    beamConfigFault && !lockedState && errorCode == 8'h00 |=>
      !safetySwitchingOutput && errorCode == `GSFS_E60;
  endproperty
  a_beam: assert property (p_beam) else $error("beam fault reaction wrong");
  property p_resp;
    responseTimeExceeded && !lockedState |=> lockedState && errorCode == `GSFS_E61;
  endproperty
  a_resp: assert property (p_resp) else $error("response fault reaction wrong");
  property p_blank;
    blankingOverlap && !lockedState && errorCode == 8'h00 |=>
      !safetySwitchingOutput && errorCode == `GSFS_E62;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking fault reaction wrong");
  property p_hold;
    errorCode != 8'h00 && !$rose(restartButton) && !polarityModeChange &&
      !responseTimeExceeded |=> errorCode == $past(errorCode) && !safetySwitchingOutput;
  endproperty
  a_hold: assert property (p_hold) else $error("fault code not held");
  property p_stuck;
    lockedState |=> lockedState && !safetySwitchingOutput;
  endproperty
  a_stuck: assert property (p_stuck) else $error("locked state left");
  property p_inter;
    (!safetySwitchingOutput && !lockedState && errorCode == 8'h00) [*3] ##0
      $rose(gatingControl) |=> errorCode == `GSFS_E74;
  endproperty
  a_inter: assert property (p_inter) else $error("interlock start code wrong");
  property p_bus;
    clkEn && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule
bind gsfs_supervisor gsfs_supervisor_checker i_chk (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
  .gatingControl(gatingControl), .restartButton(restartButton),
  .polarityModeChange(polarityModeChange), .beamConfigFault(beamConfigFault),
  .responseTimeExceeded(responseTimeExceeded), .blankingOverlap(blankingOverlap),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .safetySwitchingOutput(safetySwitchingOutput), .lockedState(lockedState),
  .errorCode(errorCode));

// File: test/gsfs_supervisor_tb_top.sv
// Self-checking bench of the gating sequence fault supervisor
`timescale 1ns/1ns
`include "gsfs_defs.vh"
module gsfs_supervisor_tb_top;
  localparam int TK = 10;
  logic ref_clk, rst, field, ctrlReq, extReq, restartReq, ctl, ext, resBtn;
  logic polar, beam, resp, blank, rd, wr, waitreq, out, locked, irq, sync;
  logic [2:0] mode;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [7:0] code;
  int n_mismatch, total_checks, seed;
  gsfs_controller_model i_ctl (.ref_clk(ref_clk), .rst(rst), .reqCtrl(ctrlReq),
    .reqExt(extReq), .reqRestart(restartReq), .gatingControl(ctl),
    .gatingExtensionSignal(ext), .restartButton(resBtn));
  gsfs_supervisor #(.TICK_CYCLES(TK)) i_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1),
    .gatingControl(ctl), .gatingExtensionSignal(ext), .fieldInterrupted(field),
    .syncInterrupted(sync), .restartButton(resBtn), .operatingModeNumber(mode),
    .polarityModeChange(polar), .beamConfigFault(beam), .responseTimeExceeded(resp),
    .blankingOverlap(blank), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .safetySwitchingOutput(out), .lockedState(locked), .errorCode(code), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ------
  // Shared tasks
  // ------
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    total_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Holds the request until waitrequest is sampled low, then idles a cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      chk(0, 1);
      final_report;
    end
    @(posedge ref_clk);
  endtask
  task automatic wait_code(input logic [7:0] exp, input int lim);
    int k;
    k = 0;
    while (code !== exp && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    chk(exp, code);
    if (code !== exp) final_report;
  endtask
  task automatic restart;
    cyc(2);
    restartReq <= 1'b1;
    cyc(3);
    restartReq <= 1'b0;
    cyc(3);
    chk(0, code);
    chk(1, out);
    $display("test done at %0t", $time);
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    rst = 1'b1;
    {field, ctrlReq, extReq, restartReq, polar, beam, resp, blank, rd, wr, sync} = '0;
    mode = 3'h2;
    addr = 5'h00;
    wdata = 32'h0;
    seed = $urandom(21);
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    chk(0, code);
    chk(1, out);
    bus(0, `GSFS_OFS_MASK, 0);
    chk(`GSFS_MASK_RST, got);
    bus(0, `GSFS_OFS_CONTROL, 0);
    chk(`GSFS_CTRL_RST, got);
    bus(0, 5'h14, 0);
    chk(0, got);
    bus(1, `GSFS_OFS_MASK, 32'h4);
    for (int i = 0; i < 3; i++) begin
      mode <= 3'($urandom_range(3, 2));
      ctrlReq <= 1'b1;
      extReq <= 1'($urandom);
      cyc(5);
      field <= 1'b1;
      cyc($urandom_range(20, 5));
      field <= 1'b0;
      cyc(5);
      ctrlReq <= 1'b0;
      extReq <= 1'b0;
      cyc(5);
      chk(0, code);
      chk(1, out);
    end
    bus(0, `GSFS_OFS_STATE, 0);
    chk(8'h01, got[7:0]);
    chk(1, irq);
    bus(1, `GSFS_OFS_STATUS, 32'h7);
    cyc(2);
    chk(0, irq);
    $display("test done at %0t", $time);
    for (int j = 0; j < 2; j++) begin
      if (j == 0) beam <= 1'b1;
      else blank <= 1'b1;
      wait_code(j ? `GSFS_E62 : `GSFS_E60, 10);
      chk(0, out);
      cyc($urandom_range(50, 5));
      beam <= 1'b0;
      blank <= 1'b0;
      chk(j ? `GSFS_E62 : `GSFS_E60, code);
      restart;
    end
    field <= 1'b1;
    cyc(5);
    field <= 1'b0;
    cyc(3);
    chk(0, out);
    ctrlReq <= 1'b1;
    wait_code(`GSFS_E74, 10);
    ctrlReq <= 1'b0;
    restart;
    mode <= 3'h1;
    field <= 1'b1;
    cyc(TK * 30);
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b0;
    cyc(5);
    ctrlReq <= 1'b0;
    cyc(5);
    chk(0, code);
    field <= 1'b1;
    cyc(TK * 40);
    ctrlReq <= 1'b1;
    wait_code(`GSFS_E63, 10);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    restart;
    mode <= 3'h2;
    ctrlReq <= 1'b1;
    cyc(TK * 45);
    field <= 1'b1;
    wait_code(`GSFS_E64, 10);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    restart;
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(5);
    restartReq <= 1'b1;
    cyc(3);
    restartReq <= 1'b0;
    cyc(3);
    ctrlReq <= 1'b0;
    wait_code(`GSFS_E66, 10);
    field <= 1'b0;
    restart;
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(5);
    field <= 1'b0;
    cyc(5);
    field <= 1'b1;
    wait_code(`GSFS_E71, 10);
    field <= 1'b0;
    cyc(3);
    field <= 1'b1;
    cyc(5);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    restart;
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(5);
    field <= 1'b0;
    cyc(TK * 200);
    wait_code(`GSFS_E75, 30);
    ctrlReq <= 1'b0;
    restart;
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(TK * 600);
    wait_code(`GSFS_E79, 30);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    restart;
    sync <= 1'b1;
    cyc(TK * 600);
    wait_code(`GSFS_E70, 30);
    sync <= 1'b0;
    restart;
    mode <= 3'h1;
    ctrlReq <= 1'b1;
    extReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(5);
    restartReq <= 1'b1;
    cyc(3);
    restartReq <= 1'b0;
    cyc(3);
    extReq <= 1'b0;
    wait_code(`GSFS_E67, 10);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    restart;
    mode <= 3'h5;
    ctrlReq <= 1'b1;
    cyc(TK * 10);
    ctrlReq <= 1'b0;
    wait_code(`GSFS_E76, 10);
    restart;
    resp <= 1'b1;
    wait_code(`GSFS_E61, 10);
    resp <= 1'b0;
    restartReq <= 1'b1;
    cyc(5);
    restartReq <= 1'b0;
    cyc(3);
    chk(`GSFS_E61, code);
    chk(1, locked);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    chk(0, locked);
    mode <= 3'h2;
    ctrlReq <= 1'b1;
    cyc(5);
    field <= 1'b1;
    cyc(5);
    restartReq <= 1'b1;
    cyc(3);
    restartReq <= 1'b0;
    cyc(TK * 1200);
    wait_code(`GSFS_E68, 40);
    chk(0, out);
    chk(0, locked);
    cyc(TK * 300 + 30);
    chk(1, locked);
    field <= 1'b0;
    ctrlReq <= 1'b0;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    chk(0, locked);
    polar <= 1'b1;
    cyc(1);
    polar <= 1'b0;
    wait_code(`GSFS_E41, 10);
    chk(1, locked);
    $display("test done at %0t", $time);
    final_report;
  end
endmodule
